// *** pcd_assertions.sv ***
`timescale 1ns/1ps
module pcd_checker
#(
  parameter int PINS = 8
)
(
  input wire logic CLK_SYS,
  input wire logic SYS_RST,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic AVS_WAITREQUEST,
  input wire logic [PINS-1:0] PORT_PIN_X,
  input wire logic CORE_SLEEPING,
  input wire logic IRQ,
  input wire logic WAKE_REQ,
  input wire logic CHANGE_INT_SUMMARY_FLAG
);
  // ==========
  // relations
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (SYS_RST);
  sequence req_wait;
    (AVS_READ || AVS_WRITE) && AVS_WAITREQUEST;
  endsequence
  sequence answer;
    !AVS_WAITREQUEST ##1 AVS_WAITREQUEST;
  endsequence
  bus_answer_a: assert property (req_wait |=> answer)
    else $error("late answer");
  bus_idle_a: assert property (!(AVS_READ || AVS_WRITE) |=> AVS_WAITREQUEST)
    else $error("stray answer");
  irq_sum_a: assert property (IRQ |-> CHANGE_INT_SUMMARY_FLAG)
    else $error("irq without flag");
  irq_cause_a: assert property ($rose(IRQ) |-> $rose(CHANGE_INT_SUMMARY_FLAG)
    || $past(AVS_WRITE) || $past(AVS_WRITE, 2)) else $error("irq cause");
  wake_gate_a: assert property (WAKE_REQ |-> IRQ)
    else $error("wake without irq");
  sleep_only_a: assert property (!$past(CORE_SLEEPING) |-> !WAKE_REQ)
    else $error("wake while awake");
  flag_cause_a: assert property ($rose(CHANGE_INT_SUMMARY_FLAG) |->
    $past(PORT_PIN_X, 2) != $past(PORT_PIN_X, 5)) else $error("flag without edge");
  flag_clear_a: assert property ($fell(CHANGE_INT_SUMMARY_FLAG) |-> $past(AVS_WRITE))
    else $error("flag lost");
endmodule
bind pin_change_irq pcd_checker #(.PINS(PINS)) pcd_checker_inst (.CLK_SYS, .SYS_RST,
  .AVS_READ, .AVS_WRITE, .AVS_WAITREQUEST, .PORT_PIN_X, .CORE_SLEEPING, .IRQ, .WAKE_REQ,
  .CHANGE_INT_SUMMARY_FLAG);

// *** pcd_pkg.sv ***
package pcd_pkg;
  // ==================================================
  // register map (word aligned byte addresses)
  localparam int ADDR_W = 4;
  localparam logic [3:0] OFS_RISE = 4'h0;
  localparam logic [3:0] OFS_FALL = 4'h4;
  localparam logic [3:0] OFS_FLAGS = 4'h8;
  localparam logic [3:0] OFS_CTRL = 4'hC;
  // ==================================================
  // field positions and reset values
  localparam int CTRL_MASTER_BIT = 0;
  localparam int CTRL_SLEEP_BIT = 1;
  localparam int CTRL_SUMMARY_BIT = 8;
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [31:0] RD_ZERO = 32'h0000_0000;
  localparam int PIN_N = 8;
  typedef enum logic [1:0] {
    BUS_IDLE = 2'b00,
    BUS_ANSWER = 2'b01
  } bus_state_t;
endpackage

// *** pin_change_irq.sv ***
`timescale 1ns/1ps
// Contract
// - pin flag sets on enabled rising or falling edge of that pin.
// - interrupt request raised only while master enable set; flags set regardless.
// - summary flag is OR of all eight pin flags.
// - writing zero to a flag clears it unless an edge arrives together.
// - edge during flag write leaves flag set whatever was written.
// - with master enable set, an enabled edge in sleep requests wake-up.
// - sleep edge is recorded in flags before core resumes.
// - rising enable register, eight RW bits, reset zero.
// - falling enable register, eight RW bits, reset zero.
// - flag register, RW and hardware set, reset zero.
// - both enables set detects edges in both directions.
// - detection continues with master enable clear; only request suppressed.
module pin_change_irq
  import pcd_pkg::*;
#(
  parameter int PINS = 8
)
(
  input wire logic CLK_SYS,
  input wire logic SYS_RST,
  input wire logic [pcd_pkg::ADDR_W-1:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  input wire logic [3:0] AVS_BYTEENABLE,
  output logic [31:0] AVS_READDATA,
  output logic AVS_WAITREQUEST,
  input wire logic [PINS-1:0] PORT_PIN_X,
  input wire logic CORE_SLEEPING,
  output logic IRQ,
  output logic WAKE_REQ,
  output logic CHANGE_INT_SUMMARY_FLAG
);
  import pcd_pkg::*;

  if (PINS != PIN_N)
  begin : pins_check
    $error("PINS must equal 8: register layout is one byte wide");
  end

  // ==================================================
  // registers
  bus_state_t bus_state;
  bus_state_t next_bus_state;
  logic [7:0] rising_edge_enable;
  logic [7:0] falling_edge_enable;
  logic [7:0] pin_change_flags;
  logic change_int_master_enable;
  logic [7:0] next_rising_edge_enable;
  logic [7:0] next_falling_edge_enable;
  logic [7:0] next_pin_change_flags;
  logic next_change_int_master_enable;
  logic [31:0] next_readdata;
  logic next_waitrequest;
  logic next_irq;
  logic next_wake;
  logic next_summary;
  logic [7:0] edge_hit;
  logic wr_take;
  logic wr_lane0;

  pin_edge_detect #(.N(PINS)) u_detect
  (
    .clk(CLK_SYS),
    .rst(SYS_RST),
    .pin_in(PORT_PIN_X),
    .rise_en(rising_edge_enable),
    .fall_en(falling_edge_enable),
    .edge_hit(edge_hit)
  );

  function automatic logic [31:0] read_mux(input logic [3:0] a);
    logic [31:0] r;
    r = RD_ZERO;
    unique case (a)
      OFS_RISE: r[7:0] = rising_edge_enable;
      OFS_FALL: r[7:0] = falling_edge_enable;
      OFS_FLAGS: r[7:0] = pin_change_flags;
      OFS_CTRL:
      begin
        r[CTRL_MASTER_BIT] = change_int_master_enable;
        r[CTRL_SLEEP_BIT] = CORE_SLEEPING;
        r[CTRL_SUMMARY_BIT] = |pin_change_flags;
      end
      default: r = RD_ZERO;
    endcase
    return r;
  endfunction

  // ==================================================
  // avalon slave: one wait cycle, answer on second cycle
  always_comb
  begin
    next_bus_state = bus_state;
    next_waitrequest = 1'b1;
    next_readdata = AVS_READDATA;
    wr_take = 1'b0;
    unique case (bus_state)
      BUS_IDLE:
      begin
        if (AVS_READ || AVS_WRITE)
        begin
          next_bus_state = BUS_ANSWER;
          next_waitrequest = 1'b0;
          next_readdata = AVS_READ ? read_mux(AVS_ADDRESS) : RD_ZERO;
        end
      end
      BUS_ANSWER:
      begin
        // request is completed at this edge; write lands here exactly once
        wr_take = AVS_WRITE;
        next_bus_state = BUS_IDLE;
      end
      default: next_bus_state = BUS_IDLE;
    endcase
  end

  // ==================================================
  // register file and flags
  always_comb
  begin
    wr_lane0 = wr_take && AVS_BYTEENABLE[0];
    next_rising_edge_enable = rising_edge_enable;
    next_falling_edge_enable = falling_edge_enable;
    next_change_int_master_enable = change_int_master_enable;
    next_pin_change_flags = pin_change_flags;
    if (wr_lane0 && AVS_ADDRESS == OFS_RISE)
    begin
      next_rising_edge_enable = AVS_WRITEDATA[7:0];
    end
    if (wr_lane0 && AVS_ADDRESS == OFS_FALL)
    begin
      next_falling_edge_enable = AVS_WRITEDATA[7:0];
    end
    if (wr_lane0 && AVS_ADDRESS == OFS_CTRL)
    begin
      next_change_int_master_enable = AVS_WRITEDATA[CTRL_MASTER_BIT];
    end
    if (wr_lane0 && AVS_ADDRESS == OFS_FLAGS)
    begin
      // written zeros clear, written ones keep (AND-style write)
      next_pin_change_flags = pin_change_flags & AVS_WRITEDATA[7:0];
    end
    // set wins over the clear; independent of master enable and sleep
    next_pin_change_flags = next_pin_change_flags | edge_hit;
    next_summary = |next_pin_change_flags;
    next_irq = change_int_master_enable && (|next_pin_change_flags);
    // wake while sleeping; flags already hold the edge by then
    next_wake = CORE_SLEEPING && change_int_master_enable && (|next_pin_change_flags);
  end

  always_ff @(posedge CLK_SYS)
  begin
    if (SYS_RST)
    begin
      bus_state <= BUS_IDLE;
      AVS_WAITREQUEST <= 1'b1;
      AVS_READDATA <= RD_ZERO;
      rising_edge_enable <= RST_BYTE;
      falling_edge_enable <= RST_BYTE;
      pin_change_flags <= RST_BYTE;
      change_int_master_enable <= 1'b0;
      IRQ <= 1'b0;
      WAKE_REQ <= 1'b0;
      CHANGE_INT_SUMMARY_FLAG <= 1'b0;
    end
    else
    begin
      bus_state <= next_bus_state;
      AVS_WAITREQUEST <= next_waitrequest;
      AVS_READDATA <= next_readdata;
      rising_edge_enable <= next_rising_edge_enable;
      falling_edge_enable <= next_falling_edge_enable;
      pin_change_flags <= next_pin_change_flags;
      change_int_master_enable <= next_change_int_master_enable;
      IRQ <= next_irq;
      WAKE_REQ <= next_wake;
      CHANGE_INT_SUMMARY_FLAG <= next_summary;
    end
  end
endmodule

// *** pin_change_irq_tb.sv ***
`timescale 1ns/1ps
module pin_change_irq_tb;
  import pcd_pkg::*;
  typedef struct {logic [3:0] a; logic [7:0] w; logic [31:0] e;} row_t;
  row_t rows [5] = '{'{OFS_RISE, 8'hA5, 32'h0000_00A5}, '{OFS_FALL, 8'hFF, 32'h0000_00FF},
    '{4'h2, 8'hFF, 32'h0000_0000}, '{OFS_FLAGS, 8'hFF, 32'h0000_0000},
    '{OFS_CTRL, 8'h01, 32'h0000_0001}};
  logic clk = 0, rst = 1, rd = 0, wr = 0, slp = 0, irq, wake, sum, wt;
  logic [3:0] adr = 4'h0;
  logic [3:0] be = 4'hF;
  logic [31:0] wd = 32'h0000_0000, rdat, got;
  logic [7:0] lvl = 8'h00, pins;
  int n_mismatch = 0, check_count = 0, cyc = 0;
  // ==========
  // clock, pins, block
  always #2 clk = ~clk;
  pin_source pin_source_inst (.clk(clk), .level(lvl), .pins(pins));
  pin_change_irq pin_change_irq_inst (.CLK_SYS(clk), .SYS_RST(rst), .AVS_ADDRESS(adr),
    .AVS_READ(rd), .AVS_WRITE(wr), .AVS_WRITEDATA(wd), .AVS_BYTEENABLE(be),
    .AVS_READDATA(rdat), .AVS_WAITREQUEST(wt), .PORT_PIN_X(pins), .CORE_SLEEPING(slp),
    .IRQ(irq), .WAKE_REQ(wake), .CHANGE_INT_SUMMARY_FLAG(sum));
  // ==========
  // tasks
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    check_count++;
    if (s !== e)
    begin
      n_mismatch++;
      $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  // waitreq is read at the rising edge; one idle edge keeps back-to-back calls apart
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    adr <= a;
    wd <= d;
    rd <= !w;
    wr <= w;
    @(posedge clk);
    while (wt !== 1'b0)
      @(posedge clk);
    got = rdat;
    rd <= 1'b0;
    wr <= 1'b0;
    @(posedge clk);
  endtask
  task automatic flags(input logic [7:0] e);
    bus(1'b0, OFS_FLAGS, 0);
    chk(got, {24'h00_0000, e});
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 2000)
    begin
      n_mismatch++;
      end_sim();
    end
  end
  // ==========
  // sequence
  initial
  begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    foreach (rows[i])
    begin
      bus(1'b0, rows[i].a, 0);
      chk(got, 0);
      bus(1'b1, rows[i].a, {24'h00_0000, rows[i].w});
      bus(1'b0, rows[i].a, 0);
      chk(got, rows[i].e);
    end
    lvl <= 8'hFF;
    repeat (6) @(posedge clk);
    chk(sum, 1);
    chk(irq, 1);
    flags(8'hA5);
    bus(1'b1, OFS_FLAGS, 32'h0000_005A);
    flags(8'h00);
    lvl <= 8'h00;
    repeat (6) @(posedge clk);
    flags(8'hFF);
    bus(1'b1, OFS_FLAGS, 0);
    chk(irq, 0);
    bus(1'b1, OFS_CTRL, 0);
    lvl <= 8'h01;
    repeat (6) @(posedge clk);
    chk(irq, 0);
    bus(1'b0, OFS_CTRL, 0);
    chk(got, 32'h0000_0100);
    slp <= 1'b1;
    bus(1'b1, OFS_CTRL, 32'h0000_0001);
    bus(1'b1, OFS_FLAGS, 0);
    lvl <= 8'h00;
    repeat (6) @(posedge clk);
    chk(wake, 1);
    flags(8'h01);
    slp <= 1'b0;
    bus(1'b1, OFS_FLAGS, 0);
    lvl <= 8'h01;
    repeat (2) @(posedge clk);
    bus(1'b1, OFS_FLAGS, 0);
    flags(8'h01);
    be <= 4'hE;
    bus(1'b1, OFS_RISE, 32'h0000_00FF);
    be <= 4'hF;
    bus(1'b0, OFS_RISE, 0);
    chk(got, 32'h0000_00A5);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    chk(wt, 1);
    chk(irq, 0);
    chk(sum, 0);
    rst <= 1'b0;
    flags(8'h00);
    bus(1'b0, OFS_RISE, 0);
    chk(got, 0);
    bus(1'b0, OFS_FALL, 0);
    chk(got, 0);
    end_sim();
  end
endmodule

// *** pin_edge_detect.sv ***
`timescale 1ns/1ps
module pin_edge_detect
#(
  parameter int N = 8
)
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [N-1:0] pin_in,
  input wire logic [N-1:0] rise_en,
  input wire logic [N-1:0] fall_en,
  output logic [N-1:0] edge_hit
);
  // ==================================================
  // two-stage synchroniser plus previous sample
  logic [N-1:0] sync_a;
  logic [N-1:0] sync_b;
  logic [N-1:0] prev;
  logic [N-1:0] next_sync_a;
  logic [N-1:0] next_sync_b;
  logic [N-1:0] next_prev;

  always_comb
  begin
    next_sync_a = pin_in;
    next_sync_b = sync_a;
    next_prev = sync_b;
    edge_hit = (rise_en & sync_b & ~prev) | (fall_en & ~sync_b & prev);
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      sync_a <= '0;
      sync_b <= '0;
      prev <= '0;
    end
    else
    begin
      sync_a <= next_sync_a;
      sync_b <= next_sync_b;
      prev <= next_prev;
    end
  end
endmodule

// *** pin_source.sv ***
`timescale 1ns/1ps
module pin_source
#(
  parameter int N = 8
)
(
  input wire logic clk,
  input wire logic [N-1:0] level,
  output logic [N-1:0] pins
);
  // ==========
  // pins move just after an edge, so the sampling edge never races them
  initial pins = '0;
  always @(posedge clk)
    pins <= level;
endmodule
